// *** hw/rsr_pkg.sv ***
// Constants for the reset source and record logic.
// Assumes a 100 MHz system clock and APB register access.
package rsr_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [11:0] ADDR_CAUSE    = 12'h000;
    localparam logic [11:0] ADDR_CONTROL  = 12'h004;
    localparam logic [11:0] ADDR_WDOG     = 12'h008;
    localparam logic [11:0] ADDR_STATUS   = 12'h00c;

    // ************************************************************
    // Cause record bit positions and reset value
    // ************************************************************
    localparam int BIT_LOCKUP      = 7;
    localparam int BIT_CFG_FAIL    = 6;
    localparam int BIT_WAKEUP      = 5;
    localparam int BIT_SOFTWARE    = 4;
    localparam int BIT_WATCHDOG    = 3;
    localparam int BIT_PIN         = 2;
    localparam int BIT_CORE_SUPPLY = 1;
    localparam int BIT_AON_SUPPLY  = 0;
    localparam logic [7:0] CAUSE_RESET = 8'h01;

    // Control register fields
    localparam int CTL_WDOG_EN     = 0;
    localparam int CTL_EMUL_SLEEP  = 1;
    localparam int CTL_DEBUG_SW    = 2;
    localparam int CTL_DEBUG_OFF   = 3;

    // ************************************************************
    // Timing and counts
    // ************************************************************
    localparam int CLK_HZ          = 100_000_000;
    localparam int REF_HZ          = 1_000;
    localparam int REF_DIV         = CLK_HZ / REF_HZ;
    localparam logic [1:0] CFG_RETRY_MAX = 2'h3;
    localparam logic [15:0] WDOG_RESET   = 16'h03e8;
    localparam logic [3:0] PULSE_LEN     = 4'h8;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_RESET  = 3'b001,
        ST_SLEEP  = 3'b010,
        ST_WAKE   = 3'b011,
        ST_GIVEUP = 3'b100
    } rsr_state_t;

endpackage

// *** hw/rsr_top.sv ***
// Reset source gathering, domain reset generation and cause record.
// Assumes synchronous request inputs except the two reset pins and power detects,
// which are synchronised here. Registers reached over APB.
//
// How it works
// - A watchdog ticking at 1 kHz raises a reset request on expiry.
// - The processor software reset request is taken as software reset source.
// - A failed configuration check from flash raises the config fail source.
// - After config failure the check repeats, giving up on the third.
// - Giving up enters emulated deep sleep and forces readout protection.
// - Debug port reset request resets the processor only.
// - Test reset pin resets only the TAP, independent of the other reset sources.
// - Test reset pin ignored in two-wire mode or with debug off.
// - Power manager signals sleep entry and exit to this block.
// - Sleep reset held from entry until core power detect is good.
// - Emulated sleep keeps core and memory powered.
// - Deep sleep removes core and flash power, keeps always-on.
// - The cause of the last restart is recorded.
// - Cause flags exclusive, config fail and lockup may join the original cause.
// - Lockup sets a flag and applies no reset.
// - All sources meet here; outputs depend on source and sleep state.
// - Always-on peripheral reset separate from core peripheral reset.
// - Processor-only reset leaves debug logic alone.
// - Record bits: 7 lockup down to 0 always-on supply.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module rsr_top
    import rsr_pkg::*;
(
    input  wire logic        REF_CLK,              // 100 MHz system clock
    input  wire logic        RST,                  // Async reset, active high
    input  wire logic        CLK_EN,               // Freezes all state when low
    input  wire logic        PSEL,                 // APB select
    input  wire logic        PENABLE,              // APB access phase
    input  wire logic        PWRITE,               // APB direction
    input  wire logic [11:0] PADDR,                // APB byte address
    input  wire logic [31:0] PWDATA,               // APB write data
    output logic      [31:0] PRDATA,               // APB read data
    output logic             PREADY,               // APB ready
    output logic             PSLVERR,              // APB error, unmapped
    input  wire logic        CPU_SOFT_RESET_REQUEST,   // Processor reset request
    input  wire logic        CONFIG_CHECK_DONE,        // Option check finished
    input  wire logic        CONFIG_CHECK_FAIL_REQUEST,// Option check failed
    input  wire logic        DEBUG_PORT_RESET_REQUEST, // Debug port reset
    input  wire logic        EXTERNAL_RESET_PIN_N,     // Reset pin, active low
    input  wire logic        TEST_RESET_PIN_N,         // Test reset pin, active low
    input  wire logic        ALWAYS_ON_POWER_DETECT,   // Always-on supply good
    input  wire logic        CORE_POWER_DETECT,        // Core supply good
    input  wire logic        SLEEP_ENTER,              // Power manager entry pulse
    input  wire logic        SLEEP_EXIT,               // Power manager wake pulse
    input  wire logic        CPU_LOCKUP,               // Unrecoverable exception
    output logic             POWER_ON_RESET,           // Processor and debug reset
    output logic             PROCESSOR_ONLY_RESET,     // Processor-only reset
    output logic             DEBUG_ACCESS_RESET,       // Debug access port reset
    output logic             ALWAYS_ON_PERIPH_RESET,   // Always-on periph reset
    output logic             CORE_PERIPH_RESET,        // Core periph reset
    output logic             TAP_RESET,                // TAP controller reset
    output logic             CORE_POWER_ENABLE,        // Core domain supply on
    output logic             FLASH_POWER_ENABLE,       // Flash supply on
    output logic             READOUT_PROTECT_FORCE     // Readout protection forced
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Test pin starts at its idle level, so no false TAP reset after release
    localparam logic [4:1] SYNC_RESET = 4'b1000;
    logic [4:1] sync1, sync2, sync3, pin_state;
    logic [4:1] raw_in;
    assign raw_in = {TEST_RESET_PIN_N, ~EXTERNAL_RESET_PIN_N,
                     ALWAYS_ON_POWER_DETECT, CORE_POWER_DETECT};

    // Three stages; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 1; gi < 5; gi++)
        begin : g_sync
            always_ff @(posedge REF_CLK or posedge RST)
            begin
                if (RST)
                begin
                    sync1[gi]     <= SYNC_RESET[gi];
                    sync2[gi]     <= SYNC_RESET[gi];
                    sync3[gi]     <= SYNC_RESET[gi];
                    pin_state[gi] <= SYNC_RESET[gi];
                end
                else if (CLK_EN)
                begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi])
                        pin_state[gi] <= sync3[gi];
                end
            end
        end
    endgenerate

    logic test_pin_n, pin_req, aon_good, core_good;
    assign test_pin_n = pin_state[4];
    assign pin_req    = pin_state[3];
    assign aon_good   = pin_state[2];
    assign core_good  = pin_state[1];

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]  cause;
    logic [3:0]  control;
    logic [15:0] wdog_reload;
    logic        apb_wr, apb_rd;
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd = PSEL && !PENABLE && !PWRITE;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == ADDR_CAUSE) || (a == ADDR_CONTROL)
              || (a == ADDR_WDOG) || (a == ADDR_STATUS);
    endfunction

    // Write side of the control registers; cause is read only
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            control     <= 4'h1;
            wdog_reload <= WDOG_RESET;
        end
        else if (CLK_EN && apb_wr)
        begin
            if (PADDR == ADDR_CONTROL)
                control <= PWDATA[3:0];
            if (PADDR == ADDR_WDOG)
                wdog_reload <= PWDATA[15:0];
        end
    end

    // ************************************************************
    // Watchdog on 1 kHz reference tick
    // ************************************************************
    logic [16:0] ref_cnt;
    logic [15:0] wdog_cnt;
    logic        wdog_req, wdog_kick;
    assign wdog_kick = apb_wr && (PADDR == ADDR_WDOG);

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            ref_cnt  <= 17'h0;
            wdog_cnt <= WDOG_RESET;
            wdog_req <= 1'b0;
        end
        else if (CLK_EN)
        begin
            wdog_req <= 1'b0;
            if (ref_cnt == 17'(REF_DIV - 1))
                ref_cnt <= 17'h0;
            else
                ref_cnt <= ref_cnt + 17'h1;
            if (wdog_kick || !control[CTL_WDOG_EN])
                wdog_cnt <= (wdog_kick) ? PWDATA[15:0] : wdog_reload;
            else if (ref_cnt == 17'(REF_DIV - 1))
            begin
                if (wdog_cnt == 16'h0)
                begin
                    wdog_req <= 1'b1;
                    wdog_cnt <= wdog_reload;
                end
                else
                    wdog_cnt <= wdog_cnt - 16'h1;
            end
        end
    end

    // ************************************************************
    // Central sequencer
    // ************************************************************
    rsr_state_t state;
    logic [7:0] pend;
    logic [1:0] cfg_tries;
    logic [3:0] hold_cnt;
    logic       in_sleep, emul;

    // One pulse-stretched reset episode per source; pend collects cause
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            state     <= ST_RESET;
            pend      <= CAUSE_RESET;
            cause     <= CAUSE_RESET;
            cfg_tries <= 2'h0;
            hold_cnt  <= PULSE_LEN;
            in_sleep  <= 1'b0;
            emul      <= 1'b0;
            READOUT_PROTECT_FORCE <= 1'b0;
        end
        else if (CLK_EN)
        begin
            case (state)
            ST_RUN:
            begin
                hold_cnt <= PULSE_LEN;
                if (!aon_good || !core_good)
                begin
                    state <= ST_RESET;
                    pend  <= (!aon_good) ? 8'h01 : 8'h02;
                end
                else if (pin_req)
                begin
                    state <= ST_RESET;
                    pend  <= 8'h04;
                end
                else if (wdog_req)
                begin
                    state <= ST_RESET;
                    pend  <= 8'h08;
                end
                else if (CPU_SOFT_RESET_REQUEST)
                begin
                    state <= ST_RESET;
                    pend  <= 8'h10;
                end
                else if (CONFIG_CHECK_DONE && CONFIG_CHECK_FAIL_REQUEST)
                begin
                    // Keep original cause, add config flag
                    pend      <= cause & 8'h7f | 8'h40;
                    cfg_tries <= cfg_tries + 2'h1;
                    state     <= (cfg_tries + 2'h1 == CFG_RETRY_MAX)
                                 ? ST_GIVEUP : ST_RESET;
                end
                else if (CONFIG_CHECK_DONE)
                    cfg_tries <= 2'h0;
                else if (SLEEP_ENTER)
                begin
                    state    <= ST_SLEEP;
                    in_sleep <= 1'b1;
                    emul     <= control[CTL_EMUL_SLEEP];
                    pend     <= 8'h20;
                end
            end
            ST_RESET:
            begin
                if (pin_req || !aon_good || !core_good)
                    hold_cnt <= PULSE_LEN;
                else if (hold_cnt != 4'h0)
                    hold_cnt <= hold_cnt - 4'h1;
                else
                begin
                    state <= ST_RUN;
                    cause <= pend;
                end
            end
            ST_SLEEP:
                if (SLEEP_EXIT)
                    state <= ST_WAKE;
            ST_WAKE:
                if (core_good || emul)
                begin
                    state    <= ST_RESET;       // Hold until supply good
                    in_sleep <= 1'b0;
                end
            ST_GIVEUP:
            begin
                READOUT_PROTECT_FORCE <= 1'b1;
                emul      <= 1'b1;
                in_sleep  <= 1'b1;
                cfg_tries <= 2'h0;
                cause     <= pend;
                state     <= ST_SLEEP;          // Recover via wake
            end
            default:
                state <= ST_RESET;
            endcase
            // After the case, so a lockup in a capture cycle is not lost
            if (CPU_LOCKUP)
                cause[BIT_LOCKUP] <= 1'b1;      // No reset applied
        end
    end

    // ************************************************************
    // Reset outputs per source and sleep state
    // ************************************************************
    logic in_rst, full_rst, aon_src, cfg_rst;
    assign in_rst   = (state != ST_RUN);
    // Config failure keeps the old cause in pend but resets as its own kind
    assign cfg_rst  = pend[BIT_CFG_FAIL];
    assign full_rst = !cfg_rst && (pend[BIT_AON_SUPPLY] | pend[BIT_CORE_SUPPLY]
                    | (pend[BIT_WAKEUP] & !emul));
    assign aon_src  = !cfg_rst && (pend[BIT_AON_SUPPLY] | pend[BIT_PIN]
                    | pend[BIT_WATCHDOG] | pend[BIT_SOFTWARE]
                    | (pend[BIT_CORE_SUPPLY] & !in_sleep));

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            POWER_ON_RESET         <= 1'b1;
            PROCESSOR_ONLY_RESET   <= 1'b1;
            DEBUG_ACCESS_RESET     <= 1'b1;
            ALWAYS_ON_PERIPH_RESET <= 1'b1;
            CORE_PERIPH_RESET      <= 1'b1;
            CORE_POWER_ENABLE      <= 1'b1;
            FLASH_POWER_ENABLE     <= 1'b1;
        end
        else if (CLK_EN)
        begin
            // Debug request only touches the processor
            PROCESSOR_ONLY_RESET <= in_rst || DEBUG_PORT_RESET_REQUEST;
            POWER_ON_RESET <= in_rst && (full_rst || pend[BIT_PIN]
                              || pend[BIT_CFG_FAIL]);
            DEBUG_ACCESS_RESET <= in_rst && full_rst;
            ALWAYS_ON_PERIPH_RESET <= in_rst && aon_src;
            CORE_PERIPH_RESET <= in_rst;
            // Sleep powers down core and flash unless emulated
            CORE_POWER_ENABLE  <= !(state == ST_SLEEP && !emul);
            FLASH_POWER_ENABLE <= !(state == ST_SLEEP && !emul);
        end
    end

    // Test reset: TAP only, ignored in two-wire mode or debug off
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            TAP_RESET <= 1'b1;
        else if (CLK_EN)
            TAP_RESET <= !test_pin_n && !control[CTL_DEBUG_SW]
                         && !control[CTL_DEBUG_OFF];
    end

    // ************************************************************
    // APB read path, one wait-free access
    // ************************************************************
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            PRDATA  <= 32'h0;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else if (CLK_EN)
        begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !mapped(PADDR);
            if (apb_rd)
            begin
                case (PADDR)
                ADDR_CAUSE:   PRDATA <= {24'h0, cause};
                ADDR_CONTROL: PRDATA <= {28'h0, control};
                ADDR_WDOG:    PRDATA <= {16'h0, wdog_cnt};
                ADDR_STATUS:  PRDATA <= {27'h0, state, READOUT_PROTECT_FORCE, in_sleep};
                default:      PRDATA <= 32'h0;
                endcase
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_lockup_no_reset: assert property (@(posedge REF_CLK) disable iff (RST)
        (state == ST_RUN && CLK_EN && CPU_LOCKUP && aon_good && core_good
         && !pin_req && !wdog_req && !CPU_SOFT_RESET_REQUEST
         && !CONFIG_CHECK_DONE && !SLEEP_ENTER) |=> state == ST_RUN)
        else $error("lockup caused a reset");
    a_wdog_resets: assert property (@(posedge REF_CLK) disable iff (RST)
        (state == ST_RUN && CLK_EN && wdog_req && aon_good && core_good && !pin_req)
        |=> pend == 8'h08)
        else $error("watchdog did not reset");
    a_tap_isolated: assert property (@(posedge REF_CLK) disable iff (RST)
        (CLK_EN && control[CTL_DEBUG_OFF]) |=> !TAP_RESET)
        else $error("test reset acted while debug off");
    a_giveup_protect: assert property (@(posedge REF_CLK) disable iff (RST)
        (state == ST_GIVEUP && CLK_EN) |=> READOUT_PROTECT_FORCE && state == ST_SLEEP)
        else $error("give up did not protect");
    a_cause_exclusive: assert property (@(posedge REF_CLK) disable iff (RST)
        $onehot(cause[5:0]))
        else $error("cause flags not exclusive");
    a_sleep_power: assert property (@(posedge REF_CLK) disable iff (RST)
        (state == ST_SLEEP && !emul && CLK_EN) |=> !FLASH_POWER_ENABLE)
        else $error("flash powered in sleep");
    a_debug_proc: assert property (@(posedge REF_CLK) disable iff (RST)
        (CLK_EN && DEBUG_PORT_RESET_REQUEST) |=> PROCESSOR_ONLY_RESET)
        else $error("debug reset not applied");
    a_cause_held: assert property (@(posedge REF_CLK) disable iff (RST)
        (state == ST_RUN && $past(state) == ST_RUN && !CPU_LOCKUP)
        |-> $stable(cause[6:0]))
        else $error("cause changed while running");

endmodule

// *** bench/rsr_far_model.sv ***
// Far-side model: the flash controller's option check run after each restart.
// Assumes it sees the core peripheral reset and one system clock.
`timescale 1ns/1ps
module rsr_far_model (
    input  wire logic       clk,         // System clock
    input  wire logic       rst,         // Async reset, active high
    input  wire logic       flash_reset, // Core domain reset
    input  wire logic [1:0] fail_budget, // Total failed checks to report
    output logic            check_done,  // Check finished pulse
    output logic            check_fail   // Check verdict, valid with done
);
    logic       prev_reset;
    logic [1:0] used;
    logic [3:0] delay;

    // Check starts a few cycles after flash leaves reset; verdict is
    // only meaningful with done, so the line toggles otherwise
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prev_reset <= 1'b1;
            used       <= 2'h0;
            delay      <= 4'h0;
            check_done <= 1'b0;
            check_fail <= 1'b0;
        end
        else
        begin
            prev_reset <= flash_reset;
            check_done <= (delay == 4'h1);
            check_fail <= (delay == 4'h1) ? (used < fail_budget) : ~check_fail;
            if (flash_reset)
                delay <= 4'h0;              // Reset aborts a running check
            else if (prev_reset)
                delay <= 4'h5;
            else if (delay != 4'h0)
                delay <= delay - 4'h1;
            if (delay == 4'h1 && used < fail_budget)
                used <= used + 2'h1;
        end
    end
endmodule

// *** bench/rsr_top_tb.sv ***
// Self-checking bench for the reset source and record logic.
// Assumes rsr_pkg, rsr_top and rsr_far_model are compiled first.
`timescale 1ns/1ps
module rsr_top_tb;
    import rsr_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        soft_req, dbg_req, pin_n, tap_n, core_ok, sl_in, sl_out, lockup;
    logic        c_done, c_fail, por, prc, dap, aon, core, tap, cpwr, fpwr, prot;
    logic [1:0]  fail_budget;
    int          miscompares = 0;
    int          check_count = 0;
    int          n_checks = 0;

    // ****************************************************
    // Instances
    // ****************************************************
    rsr_top rsr_top_i (.REF_CLK(clk), .RST(rst), .CLK_EN(1'b1), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CPU_SOFT_RESET_REQUEST(soft_req), .CONFIG_CHECK_DONE(c_done),
        .CONFIG_CHECK_FAIL_REQUEST(c_fail), .DEBUG_PORT_RESET_REQUEST(dbg_req),
        .EXTERNAL_RESET_PIN_N(pin_n), .TEST_RESET_PIN_N(tap_n),
        .ALWAYS_ON_POWER_DETECT(1'b1), .CORE_POWER_DETECT(core_ok),
        .SLEEP_ENTER(sl_in), .SLEEP_EXIT(sl_out), .CPU_LOCKUP(lockup),
        .POWER_ON_RESET(por), .PROCESSOR_ONLY_RESET(prc), .DEBUG_ACCESS_RESET(dap),
        .ALWAYS_ON_PERIPH_RESET(aon), .CORE_PERIPH_RESET(core), .TAP_RESET(tap),
        .CORE_POWER_ENABLE(cpwr), .FLASH_POWER_ENABLE(fpwr),
        .READOUT_PROTECT_FORCE(prot));
    rsr_far_model rsr_far_model_i (.clk(clk), .rst(rst), .flash_reset(core),
        .fail_budget(fail_budget), .check_done(c_done), .check_fail(c_fail));

    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic conclude();
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [5:0] outs();
        return {por, prc, dap, aon, core, tap};
    endfunction

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded wait for every domain reset to drop
    task automatic settle();
        int n;
        n = 0;
        while (outs() !== 6'h00 && n < 500)
        begin
            @(posedge clk);
            n++;
        end
        chk("release", 6'h00, outs());
        repeat (3) @(posedge clk);
    endtask

    task automatic episode(input int src, input logic [5:0] exp);
        case (src)
            0: soft_req <= 1'b1;
            1: dbg_req <= 1'b1;
            default: pin_n <= 1'b0;
        endcase
        // Short enough that a released request cannot start a second episode
        repeat (8) @(posedge clk);
        chk("domain resets", exp, outs());
        soft_req <= 1'b0;
        dbg_req  <= 1'b0;
        pin_n    <= 1'b1;
        settle();
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_regs();
        apb(0, ADDR_CAUSE, 0);
        chk("cause after power-up", CAUSE_RESET, rd);
        apb(0, ADDR_CONTROL, 0);
        chk("control reset", 32'h1, rd);
        apb(0, ADDR_WDOG, 0);
        chk("watchdog count", WDOG_RESET, rd);
        apb(1, ADDR_CAUSE, 32'hff);
        apb(0, ADDR_CAUSE, 0);
        chk("cause read-only", CAUSE_RESET, rd);
        apb(0, 12'h010, 0);
        chk("unmapped error", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
    endtask

    task automatic t_lockup();
        lockup <= 1'b1;
        repeat (20) @(posedge clk);
        chk("no reset on lockup", 6'h00, outs());
        apb(0, ADDR_CAUSE, 0);
        chk("lockup flag", 32'h1, rd[BIT_LOCKUP]);
        lockup <= 1'b0;
    endtask

    task automatic t_software();
        episode(0, 6'b010110);
        apb(0, ADDR_CAUSE, 0);
        chk("software cause", 32'h10, rd);
    endtask

    task automatic t_debug();
        episode(1, 6'b010000);
    endtask

    task automatic t_pin();
        episode(2, 6'b110110);
        apb(0, ADDR_CAUSE, 0);
        chk("pin cause", 32'h04, rd);
    endtask

    task automatic t_tap();
        logic [3:0] m;
        for (int i = 0; i < 3; i++)
        begin
            m = (i == 0) ? 4'h0 : ((i == 1) ? 4'h4 : 4'h8);
            apb(1, ADDR_CONTROL, {28'h0, m | 4'h1});
            tap_n <= 1'b0;
            repeat (8) @(posedge clk);
            chk("tap reset", (i == 0) ? 32'h1 : 32'h0, outs());
            tap_n <= 1'b1;
            repeat (8) @(posedge clk);
        end
        apb(1, ADDR_CONTROL, 32'h1);
    endtask

    task automatic t_sleep(input logic emul);
        apb(1, ADDR_CONTROL, emul ? 32'h3 : 32'h1);
        sl_in <= 1'b1;
        @(posedge clk);
        sl_in <= 1'b0;
        repeat (12) @(posedge clk);
        chk("sleep resets", emul ? 6'b010010 : 6'b111010, outs());
        chk("core power", emul, cpwr);
        chk("flash power", emul, fpwr);
        core_ok <= emul;
        repeat (20) @(posedge clk);
        sl_out <= 1'b1;
        @(posedge clk);
        sl_out <= 1'b0;
        repeat (20) @(posedge clk);
        if (!emul)
            chk("held until supply good", 32'h1, core);
        core_ok <= 1'b1;
        settle();
        apb(0, ADDR_CAUSE, 0);
        if (!emul)
            chk("wake cause", 32'h20, rd);
        apb(1, ADDR_CONTROL, 32'h1);
    endtask

    task automatic t_config();
        int n0;
        int n;
        n0 = n_checks;
        fail_budget <= 2'h3;
        soft_req <= 1'b1;
        repeat (8) @(posedge clk);
        soft_req <= 1'b0;
        n = 0;
        while (prot !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        repeat (500) @(posedge clk);
        chk("protect forced", 32'h1, prot);
        chk("checks until giving up", 32'h3, n_checks - n0);
        chk("emulated sleep power", 32'h1, cpwr);
        apb(0, ADDR_CAUSE, 0);
        chk("config fail flag", 32'h1, rd[BIT_CFG_FAIL]);
        apb(0, ADDR_STATUS, 0);
        chk("status after give-up", {27'h0, ST_SLEEP, 2'b11}, rd);
    endtask

    // ****************************************************
    // Clock, watchdog and main sequence
    // ****************************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Count completed option checks
    always @(posedge clk)
        if (c_done === 1'b1)
            n_checks++;

    // Whole run needs about 1k cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        conclude();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {soft_req, dbg_req, sl_in, sl_out, lockup} = '0;
        {pin_n, tap_n, core_ok} = 3'b111;
        fail_budget = 2'h0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        settle();
        t_regs();
        t_lockup();
        t_software();
        t_debug();
        t_pin();
        t_tap();
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_config();
        conclude();
    end
endmodule
